// ===== hdl/vcs_map.svh
`ifndef VCS_MAP_SVH
`define VCS_MAP_SVH
`define VCS_INT_VEC_BASE 16'h0000
`define VCS_XOP_VEC_BASE 16'h0040
`define VCS_LOAD_VEC 16'hfffc
`define VCS_REG_XOP_ARG 4'hb
`define VCS_REG_LINK 4'hb
`define VCS_REG_OLD_WP 4'hd
`define VCS_REG_OLD_PC 4'he
`define VCS_REG_OLD_ST 4'hf
`define VCS_MASK_LSB 0
`define VCS_RST_WP 16'h0000
`define VCS_RST_PC 16'h0000
`define VCS_RST_ST 16'h0000
`endif

// ===== hdl/vcs_pkg.sv
package vcs_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_B = 3'h1,
        OP_BL = 3'h2,
        OP_BRANCH_NEW_WORKSPACE = 3'h3,
        OP_RETURN_WITH_WORKSPACE = 3'h4,
        OP_XOP = 3'h5
    } op_t;
    typedef struct packed {
        op_t op;
        logic [15:0] target;
        logic [3:0] xop_num;
        logic [15:0] next_pc;
    } cmd_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD_WP = 4'h1,
        ST_RD_PC = 4'h3,
        ST_WR_13 = 4'h2,
        ST_WR_14 = 4'h6,
        ST_WR_15 = 4'h7,
        ST_WR_11 = 4'h5,
        ST_RT_13 = 4'h4,
        ST_RT_14 = 4'hc,
        ST_RT_15 = 4'hd,
        ST_BL_11 = 4'hf
    } state_t;
endpackage

// ===== hdl/vcs_pin_sync.sv
`timescale 1ns/10ps
module vcs_pin_sync #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            level_o <= '0;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_o <= s3_ff;
            end
        end
    end
endmodule // vcs_pin_sync

// ===== hdl/vcs_prio_enc.sv
`timescale 1ns/10ps
module vcs_prio_enc (
    input wire logic [15:0] req_i,
    output logic any_o,
    output logic [3:0] level_o
);
    always_comb begin
        any_o = 1'b0;
        level_o = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                level_o = 4'(i);
            end
        end
    end
endmodule // vcs_prio_enc

// ===== hdl/vector_context_switch.sv
`timescale 1ns/10ps
`include "vcs_map.svh"
// Summary of operation
// - Byte addresses over 64K; memory is 32K words; bytes taken after word fetch.
// - Interrupt vectors in low 64 bytes; each pair is new WP then new PC.
// - Level 0 is highest at 0000/0002; level 15 lowest at 003C/003E.
// - Reset acts as level 0 and is never masked.
// - A maskable request is taken only if its level number is at or below the mask.
// - An accepted interrupt reads its pair and performs a full context switch.
// - Restart uses pair FFFC/FFFE and is always serviced.
// - Extended operation n vectors through 0040 plus four n, unchecked, nestable.
// - Extended operation writes source effective address into new register 11.
// - Every context switch saves old WP, PC, status in new R13, R14, R15.
// - Shift count from register 0 uses its low four bits.
// - Register 0 is never used as an index register.
// - Branch and link puts the next address in R11, then branches.
// - Plain branch only loads the program counter.
// - Return reloads WP and PC from R13 and R14.
// - Return also reloads status from R15.
// - The WP addresses register 0 of a sixteen-word workspace.
module vector_context_switch
    import vcs_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [15:0] int_req_i,
    input wire logic load_req_i,
    input wire cmd_t cmd_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] xop_src_addr_i,
    input wire logic [15:0] shift_reg0_i,
    input wire logic [3:0] index_field_i,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output mem_req_t mem_o,
    output logic [15:0] wp_o,
    output logic [15:0] pc_o,
    output logic [15:0] st_o,
    output logic busy_o,
    output logic [3:0] shift_count_o,
    output logic index_en_o
);
    // ************************************************************
    // Input conditioning.
    // ************************************************************
    logic [16:0] pins_sync;
    logic any_int;
    logic [3:0] int_level;
    logic [3:0] mask;
    logic int_ok;
    vcs_pin_sync #(.W(17)) u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .pin_i({load_req_i, int_req_i}),
        .level_o(pins_sync)
    );
    vcs_prio_enc u_prio (
        .req_i(pins_sync[15:0]),
        .any_o(any_int),
        .level_o(int_level)
    );
    assign mask = st_o[`VCS_MASK_LSB +: 4];
    assign int_ok = any_int && (int_level <= mask);
    // ************************************************************
    // Sequencer.
    // ************************************************************
    state_t state_ff;
    logic [15:0] vec_ff;
    logic [15:0] new_wp_ff;
    logic [15:0] old_wp_ff;
    logic [15:0] old_pc_ff;
    logic [15:0] old_st_ff;
    logic [15:0] arg_ff;
    logic is_xop_ff;
    logic is_rt_ff;
    logic load_seen_ff;
    logic load_pend_ff;
    logic load_take;
    logic rst_pend_ff;
    logic op_taken;
    logic [15:0] nxt_wp_addr;
    assign op_taken = mem_o.req && mem_ack_i;
    assign load_take = (state_ff == ST_IDLE) && !rst_pend_ff && load_pend_ff;
    function automatic logic [15:0] reg_addr(input logic [15:0] wp, input logic [3:0] n);
        reg_addr = wp + {11'h000, n, 1'b0};
    endfunction
    always_comb begin
        nxt_wp_addr = is_rt_ff ? wp_o : new_wp_ff;
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            load_seen_ff <= 1'b0;
            load_pend_ff <= 1'b0;
        end else begin
            load_seen_ff <= pins_sync[16];
            if (pins_sync[16] && !load_seen_ff) begin
                load_pend_ff <= 1'b1;
            end else if (load_take) begin
                load_pend_ff <= 1'b0;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_ff <= ST_IDLE;
            mem_o <= '0;
            wp_o <= `VCS_RST_WP;
            pc_o <= `VCS_RST_PC;
            st_o <= `VCS_RST_ST;
            busy_o <= 1'b1;
            vec_ff <= `VCS_INT_VEC_BASE;
            new_wp_ff <= 16'h0000;
            old_wp_ff <= 16'h0000;
            old_pc_ff <= 16'h0000;
            old_st_ff <= 16'h0000;
            arg_ff <= 16'h0000;
            is_xop_ff <= 1'b0;
            is_rt_ff <= 1'b0;
            rst_pend_ff <= 1'b1;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    is_xop_ff <= 1'b0;
                    is_rt_ff <= 1'b0;
                    old_wp_ff <= wp_o;
                    old_pc_ff <= pc_o;
                    old_st_ff <= st_o;
                    busy_o <= 1'b1;
                    if (rst_pend_ff) begin
                        rst_pend_ff <= 1'b0;
                        vec_ff <= `VCS_INT_VEC_BASE;
                        mem_o <= '{req: 1'b1, we: 1'b0, addr: `VCS_INT_VEC_BASE, wdata: 16'h0};
                        state_ff <= ST_RD_WP;
                    end else if (load_pend_ff) begin
                        vec_ff <= `VCS_LOAD_VEC;
                        mem_o <= '{req: 1'b1, we: 1'b0, addr: `VCS_LOAD_VEC, wdata: 16'h0};
                        state_ff <= ST_RD_WP;
                    end else if (int_ok) begin
                        vec_ff <= `VCS_INT_VEC_BASE + {10'h000, int_level, 2'b00};
                        mem_o <= '{req: 1'b1, we: 1'b0,
                            addr: `VCS_INT_VEC_BASE + {10'h000, int_level, 2'b00}, wdata: 16'h0};
                        state_ff <= ST_RD_WP;
                    end else if (cmd_valid_i) begin
                        unique case (cmd_i.op)
                            OP_B: begin
                                pc_o <= cmd_i.target;
                                busy_o <= 1'b0;
                            end
                            OP_BL: begin
                                mem_o <= '{req: 1'b1, we: 1'b1,
                                    addr: reg_addr(wp_o, `VCS_REG_LINK), wdata: cmd_i.next_pc};
                                old_pc_ff <= cmd_i.target;
                                state_ff <= ST_BL_11;
                            end
                            OP_BRANCH_NEW_WORKSPACE: begin
                                old_pc_ff <= cmd_i.next_pc;
                                vec_ff <= cmd_i.target;
                                mem_o <= '{req: 1'b1, we: 1'b0, addr: cmd_i.target, wdata: 16'h0};
                                state_ff <= ST_RD_WP;
                            end
                            OP_XOP: begin
                                old_pc_ff <= cmd_i.next_pc;
                                is_xop_ff <= 1'b1;
                                arg_ff <= xop_src_addr_i;
                                vec_ff <= `VCS_XOP_VEC_BASE + {10'h000, cmd_i.xop_num, 2'b00};
                                mem_o <= '{req: 1'b1, we: 1'b0,
                                    addr: `VCS_XOP_VEC_BASE + {10'h000, cmd_i.xop_num, 2'b00},
                                    wdata: 16'h0};
                                state_ff <= ST_RD_WP;
                            end
                            OP_RETURN_WITH_WORKSPACE: begin
                                is_rt_ff <= 1'b1;
                                mem_o <= '{req: 1'b1, we: 1'b0,
                                    addr: reg_addr(wp_o, `VCS_REG_OLD_WP), wdata: 16'h0};
                                state_ff <= ST_RT_13;
                            end
                            default: begin
                                busy_o <= 1'b0;
                            end
                        endcase
                    end else begin
                        busy_o <= 1'b0;
                    end
                end
                ST_RD_WP: begin
                    if (op_taken) begin
                        new_wp_ff <= mem_rdata_i;
                        mem_o.addr <= vec_ff + 16'h0002;
                        state_ff <= ST_RD_PC;
                    end
                end
                ST_RD_PC: begin
                    if (op_taken) begin
                        pc_o <= mem_rdata_i;
                        mem_o <= '{req: 1'b1, we: 1'b1,
                            addr: reg_addr(new_wp_ff, `VCS_REG_OLD_WP), wdata: old_wp_ff};
                        state_ff <= ST_WR_13;
                    end
                end
                ST_WR_13: begin
                    if (op_taken) begin
                        mem_o.addr <= reg_addr(new_wp_ff, `VCS_REG_OLD_PC);
                        mem_o.wdata <= old_pc_ff;
                        state_ff <= ST_WR_14;
                    end
                end
                ST_WR_14: begin
                    if (op_taken) begin
                        mem_o.addr <= reg_addr(new_wp_ff, `VCS_REG_OLD_ST);
                        mem_o.wdata <= old_st_ff;
                        state_ff <= ST_WR_15;
                    end
                end
                ST_WR_15: begin
                    if (op_taken) begin
                        if (is_xop_ff) begin
                            mem_o.addr <= reg_addr(new_wp_ff, `VCS_REG_XOP_ARG);
                            mem_o.wdata <= arg_ff;
                            state_ff <= ST_WR_11;
                        end else begin
                            mem_o <= '0;
                            wp_o <= nxt_wp_addr;
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_WR_11: begin
                    if (op_taken) begin
                        mem_o <= '0;
                        wp_o <= new_wp_ff;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_RT_13: begin
                    if (op_taken) begin
                        new_wp_ff <= mem_rdata_i;
                        mem_o.addr <= reg_addr(wp_o, `VCS_REG_OLD_PC);
                        state_ff <= ST_RT_14;
                    end
                end
                ST_RT_14: begin
                    if (op_taken) begin
                        old_pc_ff <= mem_rdata_i;
                        mem_o.addr <= reg_addr(wp_o, `VCS_REG_OLD_ST);
                        state_ff <= ST_RT_15;
                    end
                end
                ST_RT_15: begin
                    if (op_taken) begin
                        wp_o <= new_wp_ff;
                        pc_o <= old_pc_ff;
                        st_o <= mem_rdata_i;
                        mem_o <= '0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_BL_11: begin
                    if (op_taken) begin
                        pc_o <= old_pc_ff;
                        mem_o <= '0;
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    mem_o <= '0;
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
    // ************************************************************
    // Operand helpers.
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            shift_count_o <= 4'h0;
            index_en_o <= 1'b0;
        end else begin
            shift_count_o <= shift_reg0_i[3:0];
            index_en_o <= (index_field_i != 4'h0);
        end
    end
    // ************************************************************
    // Checks.
    // ************************************************************
    chk_mem_even: assert property (@(posedge clock_i) disable iff (srst_i)
        mem_o.req |-> !mem_o.addr[0]) else $error("odd word address");
    chk_index_zero: assert property (@(posedge clock_i) disable iff (srst_i)
        $past(index_field_i) == 4'h0 |-> !index_en_o) else $error("r0 used as index");
    chk_shift_cnt: assert property (@(posedge clock_i) disable iff (srst_i)
        ##1 shift_count_o == $past(shift_reg0_i[3:0])) else $error("bad shift count");
    chk_save_slot: assert property (@(posedge clock_i) disable iff (srst_i)
        state_ff == ST_WR_13 |-> mem_o.we && mem_o.addr == new_wp_ff + 16'h001a)
        else $error("old wp not in r13");
    chk_xop_arg: assert property (@(posedge clock_i) disable iff (srst_i)
        state_ff == ST_WR_11 |-> mem_o.wdata == arg_ff && mem_o.addr == new_wp_ff + 16'h0016)
        else $error("xop arg not in r11");
    chk_branch_pc: assert property (@(posedge clock_i) disable iff (srst_i)
        state_ff == ST_IDLE && !rst_pend_ff && !load_pend_ff && !int_ok
        && cmd_valid_i && cmd_i.op == OP_B |=> pc_o == $past(cmd_i.target) && $stable(wp_o))
        else $error("branch wrong");
    chk_int_mask: assert property (@(posedge clock_i) disable iff (srst_i)
        state_ff == ST_IDLE && $past(state_ff) == ST_IDLE ##1 state_ff == ST_RD_WP
        && vec_ff < `VCS_XOP_VEC_BASE && !$past(cmd_valid_i) |-> $past(int_ok) || $past(rst_pend_ff, 2))
        else $error("masked interrupt taken");
    chk_load_vec: assert property (@(posedge clock_i) disable iff (srst_i)
        state_ff == ST_RD_WP && vec_ff == `VCS_LOAD_VEC |-> mem_o.addr == 16'hfffc)
        else $error("restart vector wrong");
endmodule // vector_context_switch

// ===== dv/vcs_mem_model.sv
`timescale 1ns/10ps
// ****************************************
// Word memory answering the block, with a chosen answer delay.
// ****************************************
module vcs_mem_model
    import vcs_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire mem_req_t mem_i,
    input wire logic [1:0] delay_i,
    output logic [15:0] rdata_o,
    output logic ack_o
);
    logic [15:0] mem [0:32767];
    logic [1:0] cnt_ff;

    always @(posedge clock_i) begin
        if (srst_i || !mem_i.req || ack_o) begin
            cnt_ff <= 2'h0;
            ack_o <= 1'b0;
            rdata_o <= srst_i ? 16'ha5c3 : ~rdata_o;
        end else if (cnt_ff >= delay_i) begin
            ack_o <= 1'b1;
            if (mem_i.we) begin
                mem[mem_i.addr[15:1]] <= mem_i.wdata;
                rdata_o <= ~rdata_o;
            end else begin
                rdata_o <= mem[mem_i.addr[15:1]];
            end
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            rdata_o <= ~rdata_o;
        end
    end
endmodule // vcs_mem_model

// ===== dv/vector_context_switch_tb_top.sv
`timescale 1ns/10ps
// ****************************************
// Testbench for the vectoring and context switch block.
// ****************************************
module vector_context_switch_tb_top;
    import vcs_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] int_req_i = 16'h0;
    logic load_req_i = 1'b0;
    cmd_t cmd_i = '0;
    logic cmd_valid_i = 1'b0;
    logic [15:0] xop_src_addr_i = 16'h0;
    logic [15:0] shift_reg0_i = 16'h0;
    logic [3:0] index_field_i = 4'h0;
    logic [1:0] delay = 2'h0;
    logic [15:0] mem_rdata, wp_o, pc_o, st_o, owp, opc, ost, nw, np, t;
    logic mem_ack, busy_o, index_en_o;
    logic [3:0] shift_count_o;
    mem_req_t mem_o;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    vector_context_switch i_dut (.clock_i(clock_i), .srst_i(srst_i), .int_req_i(int_req_i),
        .load_req_i(load_req_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i),
        .xop_src_addr_i(xop_src_addr_i), .shift_reg0_i(shift_reg0_i),
        .index_field_i(index_field_i), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack),
        .mem_o(mem_o), .wp_o(wp_o), .pc_o(pc_o), .st_o(st_o), .busy_o(busy_o),
        .shift_count_o(shift_count_o), .index_en_o(index_en_o));

    vcs_mem_model i_mem (.clock_i(clock_i), .srst_i(srst_i), .mem_i(mem_o), .delay_i(delay),
        .rdata_o(mem_rdata), .ack_o(mem_ack));

    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [15:0] wreg(input logic [15:0] wp, input int n);
        logic [15:0] a;
        a = wp + 16'(2 * n);
        return i_mem.mem[a[15:1]];
    endfunction

    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        i_mem.mem[a[15:1]] = d;
    endtask

    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (busy_o !== lvl && k < lim) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        check("busy_o", {15'h0, lvl}, {15'h0, busy_o});
    endtask

    task automatic run_cmd(input op_t op, input logic [15:0] tg, input logic [3:0] xn,
                           input logic [15:0] npc, input logic [15:0] src);
        int k;
        @(posedge clock_i);
        delay <= 2'($urandom_range(3, 0));
        cmd_i <= '{op: op, target: tg, xop_num: xn, next_pc: npc};
        xop_src_addr_i <= src;
        cmd_valid_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clock_i);
            #1;
            k++;
        end while (busy_o !== 1'b1 && k < 4);
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        #1;
        wait_busy(1'b0, 300);
    endtask

    task automatic ctx_chk(input logic [15:0] wp0, pc0, st0, wp1, pc1);
        check("wp_o", wp1, wp_o);
        check("pc_o", pc1, pc_o);
        check("r13", wp0, wreg(wp1, 13));
        check("r14", pc0, wreg(wp1, 14));
        check("r15", st0, wreg(wp1, 15));
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("ERROR timeout expected done seen running");
            report_and_stop;
        end
    end

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        void'($urandom(32'hf32d));
        poke(16'h0000, 16'h0100);
        poke(16'h0002, 16'h0400);
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        #1;
        wait_busy(1'b0, 300);
        ctx_chk(16'h0, 16'h0, 16'h0, 16'h0100, 16'h0400);
        $display("test reset vector done");
        t = 16'($urandom) & 16'hfffe;
        run_cmd(OP_B, t, 4'h0, 16'h0, 16'h0);
        check("b_pc", t, pc_o);
        check("b_wp", 16'h0100, wp_o);
        t = 16'($urandom) & 16'hfffe;
        np = 16'($urandom) & 16'hfffe;
        run_cmd(OP_BL, t, 4'h0, np, 16'h0);
        check("bl_pc", t, pc_o);
        check("bl_wp", 16'h0100, wp_o);
        check("bl_r11", np, wreg(16'h0100, 11));
        $display("test branches done");
        owp = wp_o;
        ost = st_o;
        nw = 16'h8000 | (16'($urandom) & 16'h3fe0);
        poke(16'h0200, nw);
        poke(16'h0202, 16'h1234);
        run_cmd(OP_BRANCH_NEW_WORKSPACE, 16'h0200, 4'h0, np + 16'h2, 16'h0);
        ctx_chk(owp, np + 16'h2, ost, nw, 16'h1234);
        poke(nw + 16'h1e, 16'h0005);
        run_cmd(OP_RETURN_WITH_WORKSPACE, 16'h0, 4'h0, 16'h0, 16'h0);
        check("rt_wp", owp, wp_o);
        check("rt_pc", np + 16'h2, pc_o);
        check("rt_st", 16'h0005, st_o);
        $display("test context switch and return done");
        for (int n = 0; n < 16; n++) begin
            owp = wp_o;
            ost = st_o;
            opc = 16'($urandom) & 16'hfffe;
            nw = 16'h8000 | (16'($urandom) & 16'h3fe0);
            np = 16'($urandom) & 16'hfffe;
            t = 16'($urandom);
            poke(16'h0040 + 16'(4 * n), nw);
            poke(16'h0042 + 16'(4 * n), np);
            run_cmd(OP_XOP, 16'h0, 4'(n), opc, t);
            ctx_chk(owp, opc, ost, nw, np);
            check("xop_r11", t, wreg(nw, 11));
        end
        $display("test extended operations done");
        owp = wp_o;
        opc = pc_o;
        ost = st_o;
        @(posedge clock_i);
        int_req_i <= 16'h0040;
        repeat (20) @(posedge clock_i);
        #1;
        check("masked_busy", 16'h0, {15'h0, busy_o});
        check("masked_wp", owp, wp_o);
        poke(16'h0014, 16'h9000);
        poke(16'h0016, 16'h2468);
        @(posedge clock_i);
        int_req_i <= 16'h0060;
        wait_busy(1'b1, 10);
        @(posedge clock_i);
        int_req_i <= 16'h0;
        wait_busy(1'b0, 300);
        ctx_chk(owp, opc, ost, 16'h9000, 16'h2468);
        $display("test interrupt done");
        owp = wp_o;
        opc = pc_o;
        ost = st_o;
        poke(16'hfffc, 16'ha000);
        poke(16'hfffe, 16'h3690);
        @(posedge clock_i);
        load_req_i <= 1'b1;
        wait_busy(1'b1, 10);
        @(posedge clock_i);
        load_req_i <= 1'b0;
        wait_busy(1'b0, 300);
        ctx_chk(owp, opc, ost, 16'ha000, 16'h3690);
        $display("test restart done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            shift_reg0_i <= 16'($urandom);
            index_field_i <= (i == 0) ? 4'h0 : 4'($urandom);
            repeat (3) @(posedge clock_i);
            #1;
            check("shift_count", {12'h0, shift_reg0_i[3:0]}, {12'h0, shift_count_o});
            check("index_en", {15'h0, index_field_i != 4'h0}, {15'h0, index_en_o});
        end
        $display("test shift count and index done");
        report_and_stop;
    end
endmodule // vector_context_switch_tb_top
